// ### hdl/amd_pkg.sv
// Constants, opcode classes and enumerations of the addressing mode decoder.
// Assumes one core clock; memories outside answer reads in the cycle the strobe is high.
package amd_pkg;
   localparam int          CPM         = 2;        // Clocks per machine cycle
   localparam int          PC_W        = 12;       // Program address width
   localparam int          STACK_DEPTH = 6;        // Return stack entries
   localparam logic [2:0]  STACK_FULL  = 3'h6;     // Depth value when full
   localparam logic [11:0] RESET_PC    = 12'h000;  // First fetch address
   localparam logic [11:0] INT_VECTOR  = 12'hff0;  // Interrupt entry, value arbitrary
   localparam logic [7:0]  SDIR_BASE   = 8'h80;    // Short direct registers 80h..83h
   localparam logic [7:0]  PTR_X       = 8'h80;    // First pointer register
   localparam logic [7:0]  PTR_Y       = 8'h81;    // Second pointer register
   // Machine cycles per instruction group
   localparam int          CYC_LDST    = 4;
   localparam int          CYC_REL     = 2;
   localparam int          CYC_BTB     = 5;
   localparam int          CYC_BITD    = 4;
   localparam int          CYC_EXT     = 4;
   localparam int          CYC_INH     = 2;
   // Opcode classes in bits 7:4 (bit 7 low means relative branch)
   localparam logic [3:0]  CLS_JP      = 4'h8;
   localparam logic [3:0]  CLS_CALL    = 4'h9;
   localparam logic [3:0]  CLS_BITD    = 4'ha;
   localparam logic [3:0]  CLS_BTB     = 4'hb;
   localparam logic [3:0]  CLS_INDX    = 4'hc;
   localparam logic [3:0]  CLS_INDY    = 4'hd;
   localparam logic [3:0]  CLS_SDIR    = 4'he;
   localparam logic [3:0]  CLS_MISC    = 4'hf;
   // Operations in bits 3:0 of the misc class
   localparam logic [3:0]  OP_LD_DIR   = 4'h0;
   localparam logic [3:0]  OP_ST_DIR   = 4'h1;
   localparam logic [3:0]  OP_IMM_ACC  = 4'h2;
   localparam logic [3:0]  LOAD_IMMEDIATE_OP = 4'h3;
   localparam logic [3:0]  OP_RET      = 4'h4;
   localparam logic [3:0]  OP_RETI     = 4'h5;
   // Branch conditions in bits 6:5
   localparam logic [1:0]  COND_NZ     = 2'h0;
   localparam logic [1:0]  COND_Z      = 2'h1;
   localparam logic [1:0]  COND_NC     = 2'h2;
   localparam logic [1:0]  COND_C      = 2'h3;
   typedef enum logic [3:0] {MODE_IMM, MODE_DIR, MODE_SDIR, MODE_EXT, MODE_REL,
                             MODE_BITD, MODE_BTB, MODE_IND, MODE_INH} amd_mode_t;
   typedef enum logic [2:0] {ST_FETCH, ST_OPCODE, ST_BYTE2, ST_BYTE3, ST_PTR,
                             ST_DATA, ST_HOLD} amd_state_t;
endpackage

// ### hdl/amd_addressing_mode_decoder.sv
// Fetch, addressing mode decode, operand address and branch target forming.
// Program and data memories answer combinationally from the registered address.
`timescale 1ns/1ps
// Summary of operation
// - Separate program, data and stack address spaces
// - Six-entry 12-bit return stack, calls and interrupts
// - Immediate operand is the last instruction byte
// - Direct mode: next byte is data address
// - Short direct selects registers 80h to 83h
// - Extended: opcode low nibble plus next byte
// - Relative branch one byte, span -15..+16
// - Condition, direction and span fields in opcode
// - Bit direct sets or clears any data bit
// - Bit test branch: three bytes, signed displacement
// - Indirect via pointer 80h or 81h, bit 4
// - Inherent instructions are one byte only
// - Six instruction groups over nine addressing modes
// - Load/store use accumulator; immediate to any location
// - Load/store four cycles, sizes, zero flag only
module amd_addressing_mode_decoder (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              intReq,
   output logic [11:0]            progAddr,
   output logic                   progRd,
   input  wire logic [7:0]        progRdata,
   output logic [7:0]             dataAddr,
   output logic [7:0]             dataWdata,
   output logic                   dataRd,
   output logic                   dataWr,
   input  wire logic [7:0]        dataRdata,
   output logic [7:0]             accOut,
   output logic                   zeroFlag,
   output logic                   carryFlag,
   output amd_pkg::amd_mode_t     modeOut,
   output logic [1:0]             instrLen,
   output logic                   instrDone,
   output logic                   intAck,
   output logic [2:0]             stackDepth
);
   amd_pkg::amd_state_t state_reg;            // Sequencer state
   logic [11:0]         pc_reg;               // Next instruction address
   logic [11:0]         instrPc_reg;          // Address of current opcode
   logic [7:0]          op_reg;               // Latched opcode
   logic [7:0]          byte2_reg;            // Latched second byte
   logic [3:0]          cnt_reg;              // Clocks since fetch
   logic [3:0]          tot_reg;              // Clocks this instruction takes
   logic                inIsr_reg;            // Blocks nested interrupts
   logic [11:0]         stack_reg [0:amd_pkg::STACK_DEPTH-1]; // Return stack
   logic                takeInt;              // Interrupt entry this cycle
   logic                pushEn;               // Save pc_reg on stack
   logic                popEn;                // Return from stack
   logic [11:0]         popPc;                // Top of stack, or pc when empty
   logic [11:0]         relTarget;            // Short relative branch target
   logic [3:0]          curCls;               // Class of incoming opcode
   logic [3:0]          curLo;                // Low nibble of incoming opcode

   // Opcode to addressing mode; own encoding covering all six groups
   function automatic amd_pkg::amd_mode_t modeOf(input logic [7:0] op);
      if (!op[7]) return amd_pkg::MODE_REL;
      unique case (op[7:4])
         amd_pkg::CLS_JP, amd_pkg::CLS_CALL:   return amd_pkg::MODE_EXT;
         amd_pkg::CLS_BITD:                    return amd_pkg::MODE_BITD;
         amd_pkg::CLS_BTB:                     return amd_pkg::MODE_BTB;
         amd_pkg::CLS_INDX, amd_pkg::CLS_INDY: return amd_pkg::MODE_IND;
         amd_pkg::CLS_SDIR:                    return amd_pkg::MODE_SDIR;
         default: begin
            // Misc class: direct, immediate or inherent
            if (op[3:0] == amd_pkg::OP_LD_DIR || op[3:0] == amd_pkg::OP_ST_DIR) return amd_pkg::MODE_DIR;
            if (op[3:0] == amd_pkg::OP_IMM_ACC || op[3:0] == amd_pkg::LOAD_IMMEDIATE_OP) return amd_pkg::MODE_IMM;
            return amd_pkg::MODE_INH;
         end
      endcase
   endfunction

   // Instruction size in bytes
   function automatic logic [1:0] lenOf(input logic [7:0] op);
      unique case (modeOf(op))
         amd_pkg::MODE_BTB:                     return 2'h3;
         amd_pkg::MODE_EXT, amd_pkg::MODE_DIR,
         amd_pkg::MODE_BITD:                    return 2'h2;
         amd_pkg::MODE_IMM: return (op[3:0] == amd_pkg::LOAD_IMMEDIATE_OP) ? 2'h3 : 2'h2;
         default:                               return 2'h1;
      endcase
   endfunction

   // Clock count of the instruction
   function automatic logic [3:0] clocksOf(input logic [7:0] op);
      int c;
      unique case (modeOf(op))
         amd_pkg::MODE_REL:  c = amd_pkg::CYC_REL;
         amd_pkg::MODE_BTB:  c = amd_pkg::CYC_BTB;
         amd_pkg::MODE_BITD: c = amd_pkg::CYC_BITD;
         amd_pkg::MODE_EXT:  c = amd_pkg::CYC_EXT;
         amd_pkg::MODE_INH:  c = amd_pkg::CYC_INH;
         default:            c = amd_pkg::CYC_LDST;
      endcase
      return 4'(c * amd_pkg::CPM);
   endfunction

   // Branch condition test against the flags
   function automatic logic condOk(input logic [1:0] cond, input logic z, input logic c);
      unique case (cond)
         amd_pkg::COND_NZ: return !z;
         amd_pkg::COND_Z:  return z;
         amd_pkg::COND_NC: return !c;
         default:          return c;
      endcase
   endfunction

   // Control decode for the stack and interrupt entry
   always_comb begin
      curCls    = progRdata[7:4];
      curLo     = progRdata[3:0];
      takeInt   = (state_reg == amd_pkg::ST_FETCH) && intReq && !inIsr_reg;
      pushEn    = takeInt || (state_reg == amd_pkg::ST_BYTE2 && op_reg[7:4] == amd_pkg::CLS_CALL);
      popEn     = (state_reg == amd_pkg::ST_OPCODE) && curCls == amd_pkg::CLS_MISC &&
                  (curLo == amd_pkg::OP_RET || curLo == amd_pkg::OP_RETI);
      popPc     = (stackDepth == 3'h0) ? pc_reg : stack_reg[3'(stackDepth - 3'h1)];
      // Forward adds span+1, backward subtracts span: -15..+16 around the branch
      relTarget = op_reg[4] ? instrPc_reg - {8'h0, op_reg[3:0]}
                            : instrPc_reg + {8'h0, op_reg[3:0]} + 12'h1;
   end

   // Return stack; a push when full is dropped, so deep nesting loses returns
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stackDepth <= 3'h0;
      end else if (pushEn && stackDepth != amd_pkg::STACK_FULL) begin
         stack_reg[stackDepth] <= pc_reg;
         stackDepth            <= stackDepth + 3'h1;
      end else if (popEn && stackDepth != 3'h0) begin
         stackDepth <= stackDepth - 3'h1;
      end
   end

   // Clock counter that pads each instruction to its cycle count
   always_ff @(posedge clk) begin
      if (sys_rst || state_reg == amd_pkg::ST_FETCH) begin
         cnt_reg <= 4'h0;
      end else begin
         cnt_reg <= cnt_reg + 4'h1;
      end
   end

   // Sequencer with the operand, address and flag datapath
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg   <= amd_pkg::ST_FETCH;
         pc_reg      <= amd_pkg::RESET_PC;
         instrPc_reg <= amd_pkg::RESET_PC;
         op_reg      <= 8'h0;
         byte2_reg   <= 8'h0;
         tot_reg     <= 4'h0;
         inIsr_reg   <= 1'b0;
         progAddr    <= amd_pkg::RESET_PC;
         progRd      <= 1'b0;
         dataAddr    <= 8'h0;
         dataWdata   <= 8'h0;
         dataRd      <= 1'b0;
         dataWr      <= 1'b0;
         accOut      <= 8'h0;
         zeroFlag    <= 1'b0;
         carryFlag   <= 1'b0;
         modeOut     <= amd_pkg::MODE_INH;
         instrLen    <= 2'h1;
         instrDone   <= 1'b0;
         intAck      <= 1'b0;
      end else begin
         // Strobes are single-cycle by default
         progRd    <= 1'b0;
         dataRd    <= 1'b0;
         dataWr    <= 1'b0;
         instrDone <= 1'b0;
         intAck    <= 1'b0;
         unique case (state_reg)
            amd_pkg::ST_FETCH: begin
               if (takeInt) begin
                  // Return address was pushed; enter the handler next cycle
                  pc_reg    <= amd_pkg::INT_VECTOR;
                  inIsr_reg <= 1'b1;
                  intAck    <= 1'b1;
               end else begin
                  progAddr    <= pc_reg;
                  progRd      <= 1'b1;
                  instrPc_reg <= pc_reg;
                  state_reg   <= amd_pkg::ST_OPCODE;
               end
            end
            amd_pkg::ST_OPCODE: begin
               op_reg    <= progRdata;
               modeOut   <= modeOf(progRdata);
               instrLen  <= lenOf(progRdata);
               tot_reg   <= clocksOf(progRdata);
               pc_reg    <= instrPc_reg + {10'h0, lenOf(progRdata)};
               state_reg <= amd_pkg::ST_HOLD;
               if (lenOf(progRdata) != 2'h1) begin
                  // Operand byte sits right after the opcode
                  progAddr  <= instrPc_reg + 12'h1;
                  progRd    <= 1'b1;
                  state_reg <= amd_pkg::ST_BYTE2;
               end else if (!progRdata[7]) begin
                  // Branch resolved next cycle from the latched opcode
                  state_reg <= amd_pkg::ST_DATA;
               end else if (curCls == amd_pkg::CLS_SDIR) begin
                  dataAddr <= amd_pkg::SDIR_BASE + {6'h0, curLo[1:0]};
                  if (curLo[2]) begin
                     dataWr    <= 1'b1;
                     dataWdata <= accOut;
                     zeroFlag  <= (accOut == 8'h0);
                  end else begin
                     dataRd    <= 1'b1;
                     state_reg <= amd_pkg::ST_DATA;
                  end
               end else if (curCls == amd_pkg::CLS_INDX || curCls == amd_pkg::CLS_INDY) begin
                  dataAddr  <= progRdata[4] ? amd_pkg::PTR_Y : amd_pkg::PTR_X;
                  dataRd    <= 1'b1;
                  state_reg <= amd_pkg::ST_PTR;
               end else if (popEn) begin
                  pc_reg <= popPc;
                  if (curLo == amd_pkg::OP_RETI) begin
                     inIsr_reg <= 1'b0;
                  end
               end
            end
            amd_pkg::ST_BYTE2: begin
               byte2_reg <= progRdata;
               state_reg <= amd_pkg::ST_HOLD;
               unique case (modeOut)
                  amd_pkg::MODE_EXT: begin
                     pc_reg <= {op_reg[3:0], progRdata};
                  end
                  amd_pkg::MODE_DIR: begin
                     dataAddr <= progRdata;
                     if (op_reg[3:0] == amd_pkg::OP_ST_DIR) begin
                        dataWr    <= 1'b1;
                        dataWdata <= accOut;
                        zeroFlag  <= (accOut == 8'h0);
                     end else begin
                        dataRd    <= 1'b1;
                        state_reg <= amd_pkg::ST_DATA;
                     end
                  end
                  amd_pkg::MODE_IMM: begin
                     if (op_reg[3:0] == amd_pkg::OP_IMM_ACC) begin
                        accOut   <= progRdata;
                        zeroFlag <= (progRdata == 8'h0);
                     end else begin
                        progAddr  <= instrPc_reg + 12'h2;
                        progRd    <= 1'b1;
                        state_reg <= amd_pkg::ST_BYTE3;
                     end
                  end
                  amd_pkg::MODE_BTB: begin
                     // Tested byte and displacement are read together
                     dataAddr  <= progRdata;
                     dataRd    <= 1'b1;
                     progAddr  <= instrPc_reg + 12'h2;
                     progRd    <= 1'b1;
                     state_reg <= amd_pkg::ST_BYTE3;
                  end
                  default: begin
                     // Bit direct: read the byte to modify
                     dataAddr  <= progRdata;
                     dataRd    <= 1'b1;
                     state_reg <= amd_pkg::ST_DATA;
                  end
               endcase
            end
            amd_pkg::ST_BYTE3: begin
               state_reg <= amd_pkg::ST_HOLD;
               if (modeOut == amd_pkg::MODE_BTB) begin
                  // Tested bit goes to carry; displacement gives -127..+128
                  carryFlag <= dataRdata[op_reg[2:0]];
                  if (dataRdata[op_reg[2:0]] == op_reg[3]) begin
                     pc_reg <= instrPc_reg + {{4{progRdata[7]}}, progRdata} + 12'h1;
                  end
               end else begin
                  // Immediate byte to any data location, flags untouched
                  dataAddr  <= byte2_reg;
                  dataWdata <= progRdata;
                  dataWr    <= 1'b1;
               end
            end
            amd_pkg::ST_PTR: begin
               // Pointer value is now on the data bus
               dataAddr  <= dataRdata;
               state_reg <= amd_pkg::ST_HOLD;
               if (op_reg[0]) begin
                  dataWr    <= 1'b1;
                  dataWdata <= accOut;
                  zeroFlag  <= (accOut == 8'h0);
               end else begin
                  dataRd    <= 1'b1;
                  state_reg <= amd_pkg::ST_DATA;
               end
            end
            amd_pkg::ST_DATA: begin
               state_reg <= amd_pkg::ST_HOLD;
               if (modeOut == amd_pkg::MODE_REL) begin
                  if (condOk(op_reg[6:5], zeroFlag, carryFlag)) begin
                     pc_reg <= relTarget;
                  end
               end else if (modeOut == amd_pkg::MODE_BITD) begin
                  // Read-modify-write of one bit, bit 3 selects set
                  dataWr    <= 1'b1;
                  dataWdata <= op_reg[3] ? (dataRdata | (8'h1 << op_reg[2:0]))
                                         : (dataRdata & ~(8'h1 << op_reg[2:0]));
               end else begin
                  accOut   <= dataRdata;
                  zeroFlag <= (dataRdata == 8'h0);
               end
            end
            default: begin
               // Pad to the cycle count; the fetch clock is the first of them,
               // so leaving one count early keeps fetch-to-fetch at tot_reg clocks
               if (cnt_reg >= tot_reg - 4'h2) begin
                  instrDone <= 1'b1;
                  state_reg <= amd_pkg::ST_FETCH;
               end
            end
         endcase
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_imm_fetch_addr: assert property (state_reg == amd_pkg::ST_OPCODE && lenOf(progRdata) != 2'h1
      |=> progRd && progAddr == instrPc_reg + 12'h1) else $error("operand fetch address wrong");
   a_direct_addr: assert property (state_reg == amd_pkg::ST_BYTE2 && modeOut == amd_pkg::MODE_DIR
      |=> (dataRd || dataWr) && dataAddr == $past(progRdata)) else $error("direct address wrong");
   a_short_dir_addr: assert property (state_reg == amd_pkg::ST_OPCODE && curCls == amd_pkg::CLS_SDIR
      |=> dataAddr == amd_pkg::SDIR_BASE + {6'h0, $past(curLo[1:0])})
      else $error("short direct address wrong");
   a_ext_target: assert property (state_reg == amd_pkg::ST_BYTE2 && modeOut == amd_pkg::MODE_EXT
      |=> pc_reg == {op_reg[3:0], $past(progRdata)}) else $error("extended target wrong");
   a_rel_span: assert property (state_reg == amd_pkg::ST_DATA && modeOut == amd_pkg::MODE_REL
      |=> $signed(pc_reg - instrPc_reg) >= -12'sd15 && $signed(pc_reg - instrPc_reg) <= 12'sd16)
      else $error("relative target out of span");
   a_stack_bound: assert property (stackDepth <= amd_pkg::STACK_FULL) else $error("stack depth beyond six");
   a_ind_pointer: assert property (state_reg == amd_pkg::ST_OPCODE
      && (curCls == amd_pkg::CLS_INDX || curCls == amd_pkg::CLS_INDY)
      |=> dataRd && dataAddr == ($past(progRdata[4]) ? amd_pkg::PTR_Y : amd_pkg::PTR_X))
      else $error("pointer select wrong");
   a_inherent_len: assert property (state_reg == amd_pkg::ST_OPCODE
      && modeOf(progRdata) == amd_pkg::MODE_INH |=> instrLen == 2'h1 && !progRd)
      else $error("inherent fetched operand");
   a_btb_carry: assert property (state_reg == amd_pkg::ST_BYTE3 && modeOut == amd_pkg::MODE_BTB
      |=> carryFlag == $past(dataRdata[op_reg[2:0]])) else $error("tested bit not in carry");
   // The done pulse falls in the next fetch clock, where the count has reached cycles minus one
   a_ldst_cycles: assert property (instrDone && (modeOut == amd_pkg::MODE_IMM
      || modeOut == amd_pkg::MODE_DIR || modeOut == amd_pkg::MODE_SDIR || modeOut == amd_pkg::MODE_IND)
      |-> cnt_reg == 4'(amd_pkg::CYC_LDST * amd_pkg::CPM - 1)
      && $past(cnt_reg) == 4'(amd_pkg::CYC_LDST * amd_pkg::CPM - 2))
      else $error("load store not four cycles");
   a_zero_load: assert property (state_reg == amd_pkg::ST_DATA && modeOut != amd_pkg::MODE_REL
      && modeOut != amd_pkg::MODE_BITD |=> zeroFlag == (accOut == 8'h0) && $stable(carryFlag))
      else $error("zero flag wrong after load");
   c_call_push: cover property (state_reg == amd_pkg::ST_BYTE2 && op_reg[7:4] == amd_pkg::CLS_CALL);
   c_btb_taken: cover property (state_reg == amd_pkg::ST_BYTE3 && modeOut == amd_pkg::MODE_BTB
      ##1 pc_reg != instrPc_reg + 12'h3);
   c_int_entry: cover property (intAck);
endmodule

// ### tb/amd_mem_model.sv
// Program and data memory model on the far side of the decoder.
// Assumes reads answer in the same cycle as the strobe, with no wait states.
`timescale 1ns/1ps
module amd_mem_model (
   input  wire logic        clk,
   input  wire logic [11:0] progAddr,
   input  wire logic        progRd,
   output logic      [7:0]  progRdata,
   input  wire logic [7:0]  dataAddr,
   input  wire logic [7:0]  dataWdata,
   input  wire logic        dataRd,
   input  wire logic        dataWr,
   output logic      [7:0]  dataRdata
);
   logic [7:0] pmem [0:4095];  // Program space, loaded by the bench
   logic [7:0] dmem [0:255];   // Data space, kept apart from program space
   logic [7:0] lastP = 8'h00;  // Last program byte handed out
   logic [7:0] lastD = 8'h00;  // Last data byte handed out
   // Released buses show the inverse, so a late sample cannot pass by luck
   assign progRdata = progRd ? pmem[progAddr] : ~lastP;
   assign dataRdata = dataRd ? dmem[dataAddr] : ~lastD;
   // Writes land at the edge ending the strobe cycle
   always @(posedge clk) begin
      if (progRd) lastP <= pmem[progAddr];
      if (dataRd) lastD <= dmem[dataAddr];
      if (dataWr) dmem[dataAddr] <= dataWdata;
   end
endmodule

// ### tb/tb_addressing_mode_decoder.sv
// Self-checking bench: runs a short program through each addressing mode.
// Assumes the memory model answers combinationally; inputs move at falling edges.
`timescale 1ns/1ps
module tb_addressing_mode_decoder;
   logic clk = 1'b0, sys_rst = 1'b1, intReq = 1'b0;
   logic [11:0] progAddr;
   logic progRd, dataRd, dataWr, zeroFlag, carryFlag, instrDone, intAck;
   logic [7:0] progRdata, dataAddr, dataWdata, dataRdata, accOut, rr, nv, v2, pv, ptr, disp;
   logic [1:0] instrLen;
   logic [2:0] stackDepth, bitSel;
   amd_pkg::amd_mode_t modeOut;
   int n_fail = 0, check_count = 0;
   amd_addressing_mode_decoder i_amd_addressing_mode_decoder (.clk(clk), .sys_rst(sys_rst),
      .intReq(intReq), .progAddr(progAddr), .progRd(progRd), .progRdata(progRdata),
      .dataAddr(dataAddr), .dataWdata(dataWdata), .dataRd(dataRd), .dataWr(dataWr),
      .dataRdata(dataRdata), .accOut(accOut), .zeroFlag(zeroFlag), .carryFlag(carryFlag),
      .modeOut(modeOut), .instrLen(instrLen), .instrDone(instrDone), .intAck(intAck),
      .stackDepth(stackDepth));
   amd_mem_model i_amd_mem_model (.clk(clk), .progAddr(progAddr), .progRd(progRd),
      .progRdata(progRdata), .dataAddr(dataAddr), .dataWdata(dataWdata), .dataRd(dataRd),
      .dataWr(dataWr), .dataRdata(dataRdata));
   // 40 MHz core clock
   initial forever #12.5 clk = ~clk;
   // One comparison, counted and reported on failure
   task automatic chk(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask
   task automatic final_report;
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Waits for the next done pulse; clks of zero skips the spacing check
   task automatic step(input logic [1:0] len, input amd_pkg::amd_mode_t md, input int clks);
      int k;
      @(negedge clk);
      k = 1;
      while (instrDone !== 1'b1 && k < 40) begin
         @(negedge clk);
         k++;
      end
      chk(instrLen === len && modeOut === md, "size or mode");
      if (clks > 0) chk(k == clks, "clock count");
   endtask
   // Hang guard sized well past the program length
   initial begin
      #25000;
      n_fail++;
      final_report;
   end
   // Program: immediate loads, a load in each data mode, jump, branch, interrupt,
   // call, bit set, bit test branch, return, then stores in three modes
   initial begin
      void'($urandom(32'hf0ec3c91));
      rr = 8'h84 + 8'($urandom_range(0, 11));    // Kept clear of the pointer range
      nv = 8'($urandom_range(1, 255));           // Nonzero so zero must hold
      v2 = 8'($urandom_range(0, 3)) * 8'h55;      // Zero is among the choices
      pv = 8'($urandom_range(1, 255));           // Nonzero keeps JRNZ taken
      ptr = 8'h90 + 8'($urandom_range(0, 111));
      bitSel = 3'($urandom_range(0, 7));
      disp = 8'($urandom_range(2, 127));         // Forward, clear of the bit test bytes
      i_amd_mem_model.pmem[0] = 8'hf2;  i_amd_mem_model.pmem[1] = 8'h00;
      i_amd_mem_model.pmem[2] = 8'hf3;  i_amd_mem_model.pmem[3] = rr;
      i_amd_mem_model.pmem[4] = nv;     i_amd_mem_model.pmem[5] = 8'hf0;
      i_amd_mem_model.pmem[6] = rr;     i_amd_mem_model.pmem[7] = 8'he2;
      i_amd_mem_model.pmem[8] = 8'hc0;  i_amd_mem_model.pmem[9] = 8'h81;
      i_amd_mem_model.pmem[10] = 8'h40; i_amd_mem_model.pmem[12'h140] = 8'h05;
      i_amd_mem_model.pmem[12'h146] = 8'hf6;
      i_amd_mem_model.pmem[12'h147] = 8'h9a;
      i_amd_mem_model.pmem[12'h148] = 8'h00;
      i_amd_mem_model.pmem[12'h149] = 8'he5;
      i_amd_mem_model.pmem[12'h14a] = 8'hd1;
      i_amd_mem_model.pmem[12'h14b] = 8'hf1;
      i_amd_mem_model.pmem[12'h14c] = rr;
      i_amd_mem_model.pmem[12'ha00] = 8'ha8 | 8'(bitSel);
      i_amd_mem_model.pmem[12'ha01] = rr;
      i_amd_mem_model.pmem[12'ha02] = 8'hb8 | 8'(bitSel);
      i_amd_mem_model.pmem[12'ha03] = rr;
      i_amd_mem_model.pmem[12'ha04] = disp;
      i_amd_mem_model.pmem[12'ha03 + 12'(disp)] = 8'hf4;
      i_amd_mem_model.pmem[amd_pkg::INT_VECTOR] = 8'hf5;
      i_amd_mem_model.dmem[8'h80] = ptr;
      i_amd_mem_model.dmem[8'h82] = v2;
      i_amd_mem_model.dmem[ptr] = pv;
      repeat (8) @(negedge clk);
      sys_rst = 1'b0;
      step(2'h2, amd_pkg::MODE_IMM, 0);
      chk(accOut === 8'h00 && zeroFlag === 1'b1, "immediate load");
      step(2'h3, amd_pkg::MODE_IMM, 8);
      chk(i_amd_mem_model.dmem[rr] === nv && zeroFlag === 1'b1, "load immediate to data");
      step(2'h2, amd_pkg::MODE_DIR, 8);
      chk(accOut === nv && zeroFlag === 1'b0, "direct load");
      step(2'h1, amd_pkg::MODE_SDIR, 8);
      chk(accOut === v2 && zeroFlag === (v2 == 8'h00) && carryFlag === 1'b0, "short direct");
      step(2'h1, amd_pkg::MODE_IND, 8);
      chk(accOut === pv, "indirect load");
      step(2'h2, amd_pkg::MODE_EXT, 8);
      step(2'h1, amd_pkg::MODE_REL, 4);
      chk(progAddr === 12'h140, "jump target");
      step(2'h1, amd_pkg::MODE_INH, 4);
      chk(progAddr === 12'h146, "branch target");
      // Raised in a fetch clock, so entry is taken at its closing edge
      intReq = 1'b1;
      @(negedge clk);
      intReq = 1'b0;
      chk(intAck === 1'b1 && stackDepth === 3'h1, "interrupt entry");
      step(2'h1, amd_pkg::MODE_INH, 4);
      chk(stackDepth === 3'h0 && progAddr === amd_pkg::INT_VECTOR, "interrupt return");
      step(2'h2, amd_pkg::MODE_EXT, 8);
      chk(stackDepth === 3'h1, "call push");
      step(2'h2, amd_pkg::MODE_BITD, 8);
      chk(i_amd_mem_model.dmem[rr] === (nv | (8'h1 << bitSel)), "bit set");
      step(2'h3, amd_pkg::MODE_BTB, 10);
      chk(carryFlag === 1'b1, "tested bit to carry");
      step(2'h1, amd_pkg::MODE_INH, 4);
      chk(progAddr === 12'ha03 + 12'(disp) && stackDepth === 3'h0, "bit test target");
      step(2'h1, amd_pkg::MODE_SDIR, 8);
      chk(i_amd_mem_model.dmem[8'h81] === pv && zeroFlag === 1'b0, "short direct store");
      step(2'h1, amd_pkg::MODE_IND, 8);
      chk(i_amd_mem_model.dmem[pv] === pv, "indirect store");
      step(2'h2, amd_pkg::MODE_DIR, 8);
      chk(i_amd_mem_model.dmem[rr] === pv && carryFlag === 1'b1, "direct store");
      final_report;
   end
endmodule
